// *** hdl/omp_params.svh ***
// Purpose: Constants for the operating mode and pin configuration block
// Assumes: Three mode-select pins, ports A to F of eight bits
// Notes: Mode codes equal the pin levels
`ifndef OMP_PARAMS_SVH
`define OMP_PARAMS_SVH
`define OMP_MODE_INVALID 3'h0
`define OMP_MODE_1 3'h1
`define OMP_MODE_2 3'h2
`define OMP_MODE_3 3'h3
`define OMP_MODE_4 3'h4
`define OMP_MODE_5 3'h5
`define OMP_MODE_6 3'h6
`define OMP_MODE_7 3'h7
`define OMP_STATUS_RESET 8'h80
`define OMP_STATUS_FIXED_BIT 7
`define OMP_AREA_COUNT 8
`define OMP_ROM_SIZE_FULL_KB 8'h80
`define OMP_ROM_SIZE_NORMAL_KB 8'h38
`define OMP_SPACE_NORMAL_KB 16'h0040
`define OMP_SPACE_ADV_KB 16'h4000
`define OMP_PA_ADDR_MASK 8'h1f
`define OMP_PF_CTRL_MASK 8'h78
`define OMP_PF_OPT_MASK 8'h87
`define OMP_PF_CLK_MASK 8'h80
`endif

// *** hdl/omp_pkg.sv ***
// Purpose: Types for the operating mode and pin configuration block
// Assumes: omp_params.svh holds the numbers
// Notes: Pin function codes per port pin
`default_nettype none
package omp_pkg;
	typedef enum logic [1:0] {
		OMP_FN_IO = 2'h0,
		OMP_FN_ADDR = 2'h1,
		OMP_FN_DATA = 2'h2,
		OMP_FN_CTRL = 2'h3
	} omp_fn_type;
	typedef enum logic [2:0] {
		OMP_ST_RESET = 3'h1,
		OMP_ST_RUN = 3'h2,
		OMP_ST_BAD = 3'h4
	} omp_state_type;
endpackage
`default_nettype wire

// *** hdl/omp_port_mux.sv ***
// Purpose: Per-pin function select for one eight-bit port
// Assumes: Inputs already registered in the caller
// Notes: Fixed pins ignore direction; optional pins follow it
`default_nettype none
module omp_port_mux
	import omp_pkg::*;
(
	// Configuration
	input wire logic [7:0] fixed_mask,
	input wire logic [7:0] opt_mask,
	input wire logic [1:0] fn_code,
	input wire logic [7:0] dir,
	// Result
	output logic [7:0] use_bus,
	output logic [7:0] out_en
);
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_pin
			wire logic optional_on = opt_mask[i] & dir[i];
			assign use_bus[i] = fixed_mask[i] | optional_on;
			assign out_en[i] = (fn_code == OMP_FN_ADDR) ? use_bus[i] | dir[i] : dir[i];
		end
	endgenerate
endmodule
`default_nettype wire

// *** hdl/omp_mode_config.sv ***
// Purpose: Decode operating mode and steer ports A to F
// Assumes: Pins synchronised inside; config held until next reset
// Notes: Optional bus pins only take bus function when their direction bit is 1
`include "omp_params.svh"
`default_nettype none
// Summary of operation
// - Seven modes from three pins; all-zero is invalid; pins stable in operation.
// - Status register latches pin levels on read; power-on clears, manual keeps.
// - Mode 1: 64 kbyte normal space, ROM off, 8-bit bus after reset.
// - Mode 1: ports B, C address, D data, part of F control.
// - Modes 1, 2, 5: any 16-bit area gives 16-bit bus, port E data.
// - Mode 2: 64 kbyte normal space, ROM on, 8-bit bus after reset.
// - Modes 2, 6: address pins inputs after reset; direction 1 makes output.
// - Modes 2, 3: usable ROM limited to 56 of 128 kbytes.
// - Modes 3, 7: ROM on, no external access, all pins general I/O except F7, bus function when its direction bit is 1.
// - Mode 4: 16 Mbyte advanced, ROM off, 16-bit bus, all areas 16-bit; code resets all areas to 8-bit, then follows AREA_WIDE.
// - Mode 4: 8-bit bus only when every area is 8-bit.
// - Modes 4, 5: low five A pins, B, C address, D data, E data when any area is 16-bit, part F control.
// - Mode 5: 16 Mbyte advanced, ROM off, 8-bit bus, all areas 8-bit after reset.
// - Mode 6: ROM on, 16 Mbyte, A to C inputs, D data, 8-bit start.
// - Each pin gets I/O, address, data or control per mode.
// - Advanced modes 4 to 6 split space into eight areas with own widths.
module omp_mode_config
	import omp_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic POWER_ON_RESET,
	// Mode pins
	input wire logic MODE_SELECT_PIN_2,
	input wire logic MODE_SELECT_PIN_1,
	input wire logic MODE_SELECT_PIN_0,
	// Status read
	input wire logic STATUS_READ,
	output logic [7:0] MODE_STATUS_REGISTER,
	// Bus controller area widths, 1 means 16-bit
	input wire logic [7:0] AREA_WIDE,
	// Port direction bits
	input wire logic [7:0] DIR_A,
	input wire logic [7:0] DIR_B,
	input wire logic [7:0] DIR_C,
	input wire logic [7:0] DIR_E,
	input wire logic [7:0] DIR_F,
	// Mode results
	output logic [2:0] MODE,
	output logic MODE_VALID,
	output logic ADVANCED,
	output logic [15:0] SPACE_KB,
	output logic ROM_ENABLE,
	output logic [7:0] ROM_KB,
	output logic EXPANDED,
	output logic BUS_16BIT,
	output logic [7:0] AREA_WIDE_EFF,
	// Pin bus-function selects
	output logic [7:0] PA_BUS,
	output logic [7:0] PB_BUS,
	output logic [7:0] PC_BUS,
	output logic [7:0] PD_BUS,
	output logic [7:0] PE_BUS,
	output logic [7:0] PF_BUS,
	// Pin output enables for address ports
	output logic [7:0] PA_OE,
	output logic [7:0] PB_OE,
	output logic [7:0] PC_OE
);
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;
	logic [2:0] mode_q;
	logic [2:0] mode_d;
	omp_state_type state_q;
	omp_state_type state_d;
	logic [2:0] latch_q;
	logic [7:0] status_q;
	logic [7:0] area_q;
	logic [7:0] dir_a_q;
	logic [7:0] dir_b_q;
	logic [7:0] dir_c_q;
	logic [7:0] dir_e_q;
	logic [7:0] dir_f_q;

	// Pin synchronisers
	always_ff @(posedge CLK) begin
		pin_s1_q <= {MODE_SELECT_PIN_2, MODE_SELECT_PIN_1, MODE_SELECT_PIN_0};
		pin_s2_q <= pin_s1_q;
	end

	// Mode capture state machine
	always_comb begin
		state_d = state_q;
		mode_d = mode_q;
		case (state_q)
			OMP_ST_RESET: begin
				mode_d = pin_s2_q;
				state_d = (pin_s2_q == `OMP_MODE_INVALID) ? OMP_ST_BAD : OMP_ST_RUN;
			end
			OMP_ST_RUN: state_d = OMP_ST_RUN;
			OMP_ST_BAD: state_d = OMP_ST_BAD;
			default: state_d = OMP_ST_RESET;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			state_q <= OMP_ST_RESET;
			mode_q <= `OMP_MODE_INVALID;
		end else begin
			state_q <= state_d;
			mode_q <= mode_d;
		end
	end

	// Status latch, kept over manual reset
	always_ff @(posedge CLK) begin
		if (!RESET_N && POWER_ON_RESET) begin
			latch_q <= 3'h0;
		end else if (RESET_N && STATUS_READ) begin
			latch_q <= pin_s2_q;
		end
	end

	wire logic [7:0] status_d = `OMP_STATUS_RESET | {5'h00, latch_q};

	// Registered inputs from the same clock
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			area_q <= 8'h00;
			dir_a_q <= 8'h00;
			dir_b_q <= 8'h00;
			dir_c_q <= 8'h00;
			dir_e_q <= 8'h00;
			dir_f_q <= 8'h00;
			status_q <= `OMP_STATUS_RESET;
		end else begin
			area_q <= AREA_WIDE;
			dir_a_q <= DIR_A;
			dir_b_q <= DIR_B;
			dir_c_q <= DIR_C;
			dir_e_q <= DIR_E;
			dir_f_q <= DIR_F;
			status_q <= status_d;
		end
	end

	// Mode decode
	wire logic running = (state_q == OMP_ST_RUN);
	wire logic m1 = running && (mode_q == `OMP_MODE_1);
	wire logic m2 = running && (mode_q == `OMP_MODE_2);
	wire logic m3 = running && (mode_q == `OMP_MODE_3);
	wire logic m4 = running && (mode_q == `OMP_MODE_4);
	wire logic m5 = running && (mode_q == `OMP_MODE_5);
	wire logic m6 = running && (mode_q == `OMP_MODE_6);
	wire logic m7 = running && (mode_q == `OMP_MODE_7);
	wire logic adv_d = m4 | m5 | m6 | m7;
	wire logic single_chip = m3 | m7;
	wire logic exp_d = m1 | m2 | m4 | m5 | m6;
	wire logic rom_d = m2 | m3 | m6 | m7;
	wire logic [7:0] rom_kb_d = (m2 | m3) ? `OMP_ROM_SIZE_NORMAL_KB :
		((m6 | m7) ? `OMP_ROM_SIZE_FULL_KB : 8'h00);
	wire logic [15:0] space_d = adv_d ? `OMP_SPACE_ADV_KB :
		(running ? `OMP_SPACE_NORMAL_KB : 16'h0000);

	// Area widths: single-chip modes all 8-bit, modes 1 and 2 all 16-bit if any area is, others follow AREA_WIDE
	wire logic [7:0] area_eff_d = single_chip ? 8'h00 :
		(m1 | m2) ? {8{|area_q}} : area_q;
	wire logic bus16_d = exp_d && (|area_q);

	// Port function selects
	wire logic [1:0] fn_addr = OMP_FN_ADDR;
	wire logic [1:0] fn_data = OMP_FN_DATA;
	wire logic [1:0] fn_ctrl = OMP_FN_CTRL;
	wire logic [7:0] pa_fix = (m4 | m5) ? `OMP_PA_ADDR_MASK : 8'h00;
	wire logic [7:0] pa_opt = (m4 | m5 | m6) ? ~`OMP_PA_ADDR_MASK : 8'h00;
	wire logic [7:0] pa_opt6 = m6 ? `OMP_PA_ADDR_MASK : 8'h00;
	wire logic [7:0] pbc_fix = (m1 | m4 | m5) ? 8'hff : 8'h00;
	wire logic [7:0] pbc_opt = (m2 | m6) ? 8'hff : 8'h00;
	wire logic [7:0] pd_d = exp_d ? 8'hff : 8'h00;
	wire logic [7:0] pe_d = bus16_d ? 8'hff : 8'h00;
	wire logic [7:0] pf_fix = exp_d ? `OMP_PF_CTRL_MASK : 8'h00;
	wire logic [7:0] pf_opt = exp_d ? `OMP_PF_OPT_MASK : (running ? `OMP_PF_CLK_MASK : 8'h00);
	wire logic [7:0] pa_bus_w;
	wire logic [7:0] pa_oe_w;
	wire logic [7:0] pb_bus_w;
	wire logic [7:0] pb_oe_w;
	wire logic [7:0] pc_bus_w;
	wire logic [7:0] pc_oe_w;
	wire logic [7:0] pf_bus_w;

	omp_port_mux u_pa (
		.fixed_mask(pa_fix),
		.opt_mask(pa_opt | pa_opt6),
		.fn_code(fn_addr),
		.dir(dir_a_q),
		.use_bus(pa_bus_w),
		.out_en(pa_oe_w)
	);
	omp_port_mux u_pb (
		.fixed_mask(pbc_fix),
		.opt_mask(pbc_opt),
		.fn_code(fn_addr),
		.dir(dir_b_q),
		.use_bus(pb_bus_w),
		.out_en(pb_oe_w)
	);
	omp_port_mux u_pc (
		.fixed_mask(pbc_fix),
		.opt_mask(pbc_opt),
		.fn_code(fn_addr),
		.dir(dir_c_q),
		.use_bus(pc_bus_w),
		.out_en(pc_oe_w)
	);
	omp_port_mux u_pf (
		.fixed_mask(pf_fix),
		.opt_mask(pf_opt),
		.fn_code(fn_ctrl),
		.dir(dir_f_q),
		.use_bus(pf_bus_w),
		.out_en()
	);

	wire logic unused_ok = &{1'b0, fn_data, dir_e_q};

	// Registered outputs
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			MODE <= `OMP_MODE_INVALID;
			MODE_VALID <= 1'b0;
			ADVANCED <= 1'b0;
			SPACE_KB <= 16'h0000;
			ROM_ENABLE <= 1'b0;
			ROM_KB <= 8'h00;
			EXPANDED <= 1'b0;
			BUS_16BIT <= 1'b0;
			AREA_WIDE_EFF <= 8'h00;
			PA_BUS <= 8'h00;
			PB_BUS <= 8'h00;
			PC_BUS <= 8'h00;
			PD_BUS <= 8'h00;
			PE_BUS <= 8'h00;
			PF_BUS <= 8'h00;
			PA_OE <= 8'h00;
			PB_OE <= 8'h00;
			PC_OE <= 8'h00;
		end else begin
			MODE <= mode_q;
			MODE_VALID <= running;
			ADVANCED <= adv_d;
			SPACE_KB <= space_d;
			ROM_ENABLE <= rom_d;
			ROM_KB <= rom_kb_d;
			EXPANDED <= exp_d;
			BUS_16BIT <= bus16_d;
			AREA_WIDE_EFF <= area_eff_d;
			PA_BUS <= pa_bus_w;
			PB_BUS <= pb_bus_w;
			PC_BUS <= pc_bus_w;
			PD_BUS <= pd_d;
			PE_BUS <= pe_d & ~{8{unused_ok}};
			PF_BUS <= pf_bus_w;
			PA_OE <= pa_oe_w;
			PB_OE <= pb_oe_w;
			PC_OE <= pc_oe_w;
		end
	end

	always_ff @(posedge CLK) begin
		MODE_STATUS_REGISTER <= status_q;
	end
endmodule
`default_nettype wire

// *** test/omp_bus_partner.sv ***
// Purpose: Bus controller side area width source
// Assumes: Widths change only between accesses
// Notes: Updates on the rising edge
`default_nettype none
module omp_bus_partner (
	// Clock
	input wire logic clk,
	// Widths asked and shown
	input wire logic [7:0] set_wide,
	output logic [7:0] area_wide_q
);
	always_ff @(posedge clk) begin
		area_wide_q <= set_wide;
	end
endmodule
`default_nettype wire

// *** test/omp_mode_monitor.sv ***
// Purpose: Port checks for the mode decode
// Assumes: Outputs settle by the fourth edge after release
// Notes: Bound into the mode config block
`default_nettype none
module omp_mode_monitor (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Watched ports
	input wire logic [7:0] AREA_WIDE,
	input wire logic [7:0] MODE_STATUS_REGISTER,
	input wire logic [2:0] MODE,
	input wire logic MODE_VALID,
	input wire logic ADVANCED,
	input wire logic [15:0] SPACE_KB,
	input wire logic ROM_ENABLE,
	input wire logic [7:0] ROM_KB,
	input wire logic EXPANDED,
	input wire logic BUS_16BIT,
	input wire logic [7:0] PD_BUS
);
	logic [2:0] run_q;
	logic [2:0] run_d;
	logic ok;
	assign run_d = run_q + {2'h0, run_q != 3'h7};
	assign ok = run_q[2];
	always_ff @(posedge CLK) begin
		run_q <= RESET_N ? run_d : 3'h0;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	space_kb_a: assert property (ok |-> ADVANCED == MODE[2] && SPACE_KB ==
		(!MODE_VALID ? 16'h0 : MODE[2] ? 16'h4000 : 16'h0040)) else $error("space");
	rom_enable_a: assert property (ok |-> ROM_ENABLE == MODE[1] &&
		EXPANDED == (MODE_VALID && MODE[1:0] != 2'h3)) else $error("rom");
	rom_size_a: assert property (ROM_ENABLE |->
		ROM_KB == (MODE[2] ? 8'h80 : 8'h38)) else $error("rom size");
	single_chip_a: assert property (MODE_VALID && MODE[1:0] == 2'h3 |->
		PD_BUS == 8'h00 && !BUS_16BIT) else $error("single");
	data_bus_a: assert property (EXPANDED |-> PD_BUS == 8'hff) else $error("data");
	bus_width_a: assert property (ok && EXPANDED |->
		BUS_16BIT == |$past(AREA_WIDE, 2)) else $error("width");
	mode_hold_a: assert property (run_q == 3'h7 |->
		$stable(MODE) && $stable(MODE_VALID)) else $error("hold");
	status_fixed_a: assert property (ok |->
		MODE_STATUS_REGISTER[7:3] == 5'h10) else $error("status");
	cover property (MODE_VALID && MODE == 3'h4 && BUS_16BIT);
	cover property (ROM_ENABLE && ADVANCED);
	cover property (ok && !MODE_VALID);
endmodule
bind omp_mode_config omp_mode_monitor u_omp_mode_monitor (.CLK(CLK), .RESET_N(RESET_N),
	.AREA_WIDE(AREA_WIDE), .MODE_STATUS_REGISTER(MODE_STATUS_REGISTER), .MODE(MODE),
	.MODE_VALID(MODE_VALID), .ADVANCED(ADVANCED), .SPACE_KB(SPACE_KB),
	.ROM_ENABLE(ROM_ENABLE), .ROM_KB(ROM_KB), .EXPANDED(EXPANDED), .BUS_16BIT(BUS_16BIT),
	.PD_BUS(PD_BUS));
`default_nettype wire

// *** test/omp_mode_config_tb_top.sv ***
// Purpose: Directed bench for the mode decode
// Assumes: Outputs settle within four cycles
// Notes: Inputs change on the falling edge
`default_nettype none
module omp_mode_config_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK, RESET_N, por, rd, mv, adv, rom, ex, b16;
	logic [2:0] pins, mode;
	logic [7:0] sw, aw, da, db, dc, df, st, rkb, pa, pb, pc, pd, pe, pf, oa, ob, oc, eff;
	logic [15:0] sp;
	int fails, n_tests, cyc;
	omp_bus_partner u_omp_bus_partner (.clk(CLK), .set_wide(sw), .area_wide_q(aw));
	omp_mode_config u_omp_mode_config (.CLK(CLK), .RESET_N(RESET_N), .POWER_ON_RESET(por),
		.MODE_SELECT_PIN_2(pins[2]), .MODE_SELECT_PIN_1(pins[1]), .MODE_SELECT_PIN_0(pins[0]),
		.STATUS_READ(rd), .MODE_STATUS_REGISTER(st), .AREA_WIDE(aw), .DIR_A(da), .DIR_B(db),
		.DIR_C(dc), .DIR_E(8'h00), .DIR_F(df), .MODE(mode), .MODE_VALID(mv), .ADVANCED(adv),
		.SPACE_KB(sp), .ROM_ENABLE(rom), .ROM_KB(rkb), .EXPANDED(ex), .BUS_16BIT(b16),
		.AREA_WIDE_EFF(eff), .PA_BUS(pa), .PB_BUS(pb), .PC_BUS(pc), .PD_BUS(pd), .PE_BUS(pe),
		.PF_BUS(pf), .PA_OE(oa), .PB_OE(ob), .PC_OE(oc));
	task automatic tick(input int n);
		repeat (n) @(negedge CLK);
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rst(input logic [2:0] m, input logic p);
		tick(1);
		{pins, por, RESET_N} = {m, p, 1'b0};
		sw = (m == 3'h4) ? 8'hff : 8'h00;
		tick(8);
		RESET_N = 1'b1;
		tick(4);
	endtask
	task automatic t_modes;
		logic [2:0] m;
		logic x;
		logic [7:0] b;
		for (int i = 0; i < 8; i++) begin
			m = 3'(i);
			x = m inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
			b = (m inside {3'h1, 3'h4, 3'h5}) ? 8'hff : 8'h00;
			rst(m, 1'b1);
			chk(16'({mv, adv, rom, ex, b16}), 16'({m != 3'h0, m[2], m[1], x, m == 3'h4}));
			chk(16'(eff), (m == 3'h4) ? 16'h00ff : 16'h0000);
			chk(sp, m == 3'h0 ? 16'h0 : m[2] ? 16'h4000 : 16'h0040);
			chk(16'(rkb), 16'(m[1] ? (m[2] ? 8'h80 : 8'h38) : 8'h00));
			chk({pa, pb}, {(m inside {3'h4, 3'h5}) ? 8'h1f : 8'h00, b});
			chk({pc, pd}, {b, x ? 8'hff : 8'h00});
			chk({pe, pf}, {(m == 3'h4) ? 8'hff : 8'h00, x ? 8'h78 : 8'h00});
		end
		$display("mode table done");
	endtask
	task automatic t_width;
		logic [2:0] wm [4] = '{3'h1, 3'h2, 3'h5, 3'h4};
		foreach (wm[i]) begin
			rst(wm[i], 1'b1);
			sw = 8'h80;
			tick(4);
			chk({7'h0, b16, pe}, 16'h01ff);
			chk(16'(eff), wm[i][2] ? 16'h0080 : 16'h00ff);
			sw = 8'h00;
			tick(4);
			chk({7'h0, b16, pe}, 16'h0000);
			chk(16'(eff), 16'h0000);
		end
		$display("bus width done");
	endtask
	task automatic t_dir;
		rst(3'h6, 1'b1);
		{da, db, dc, df} = 32'ha53c81ff;
		tick(4);
		chk({pa, pb}, 16'ha53c);
		chk({pc, pf}, 16'h81ff);
		chk({oa, ob}, 16'ha53c);
		chk({oc, pe}, 16'h8100);
		rst(3'h2, 1'b1);
		chk({pa, pc}, 16'h0081);
		rst(3'h3, 1'b1);
		chk({pb, pf}, 16'h0080);
		chk({pa, pc}, 16'h0000);
		{da, db, dc, df} = 32'h0;
		$display("direction done");
	endtask
	task automatic t_hold_status;
		rst(3'h5, 1'b1);
		chk(16'(st), 16'h0080);
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		pins = 3'h3;
		tick(5);
		chk({4'h0, st, mv, mode}, 16'h085d);
		rst(3'h6, 1'b0);
		chk(16'(st), 16'h0085);
		rst(3'h6, 1'b1);
		chk(16'(st), 16'h0080);
		$display("hold and status done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			wrap_up;
		end
	end
	initial begin
		{RESET_N, por, rd, pins, sw, da, db, dc, df} = '0;
		t_modes;
		t_width;
		t_dir;
		t_hold_status;
		wrap_up;
	end
endmodule
`default_nettype wire
